// ===== rtl/cache_diag_pkg.sv
// Package with constants and types for the cache diagnostic access unit
// Summary of operation
// - Variants write word, read word, read keys
// - Console variants address from current address register
// - Diagnostic variants address from field pointer register
// - Cache word is sixteen data plus parity
// - Diagnostic write takes four full source words
// - Save current address, then load field pointer
// - Word 0 written with key, validity, parity
// - Source words two to four become words 1-3
// - Finish by restoring the saved current address
// - Every write stores identical key information
// - Diagnostic read returns addressed seventeen bit word
// - Key read returns keys, valid, parity, hit, LRU
// - General clear clears registers, and cache keys and LRU unless cache-only; data words kept
package cache_diag_pkg;
    localparam int WORD_W = 17;
    localparam int DATA_W = 16;
    localparam int KEY_W = 8;
    localparam int IDX_W = 6;
    localparam int ADDR_W = 16;
    // Address layout: key in [15:8], line index in [7:2], word in [1:0]
    localparam int ADDR_KEY_LSB = 8;
    localparam int ADDR_IDX_LSB = 2;
    localparam int WORDS_PER_LINE = 4;
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
    localparam logic [WORD_W-1:0] WORD_RST = 17'h00000;
    // Key read result layout in the low 22 bits of a 24-bit result
    localparam int RES_W = 24;
    localparam int RES_KEYA_LSB = 0;
    localparam int RES_VALA_BIT = 8;
    localparam int RES_PARA_BIT = 9;
    localparam int RES_KEYB_LSB = 10;
    localparam int RES_VALB_BIT = 18;
    localparam int RES_PARB_BIT = 19;
    localparam int RES_HIT_BIT = 20;
    localparam int RES_LRU_BIT = 21;

    typedef enum logic [2:0] {
        OP_CON_WRITE = 3'b000,
        OP_CON_READ = 3'b001,
        OP_DIAG_WRITE = 3'b010,
        OP_DIAG_READ = 3'b011,
        OP_KEY_READ = 3'b100
    } op_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LOAD = 3'b001,
        ST_W0 = 3'b010,
        ST_W1 = 3'b011,
        ST_W2 = 3'b100,
        ST_W3 = 3'b101,
        ST_RESTORE = 3'b110
    } state_e;

    typedef struct packed {
        logic [WORD_W-1:0] x;
        logic [WORD_W-1:0] y;
        logic [WORD_W-1:0] t;
        logic [WORD_W-1:0] l;
    } src_s;

    typedef struct packed {
        logic [KEY_W-1:0] key;
        logic valid;
        logic parity;
    } key_s;
endpackage : cache_diag_pkg

// ===== rtl/cache_diagnostic_access.sv
// Cache read/write microinstruction unit with key store and diagnostic sequencing
module cache_diagnostic_access
    import cache_diag_pkg::*;
#(
    parameter int LINES = 64
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_periodic_general_clear,
    input wire logic i_cache_only,
    input wire logic i_start,
    input wire op_e i_op,
    input wire logic [ADDR_W-1:0] i_field_ptr_reg,
    input wire logic [ADDR_W-1:0] i_addr_load,
    input wire logic i_addr_load_en,
    input wire logic [WORD_W-1:0] i_console_switches,
    input wire src_s i_src,
    input wire logic i_block_sel,
    output logic [ADDR_W-1:0] o_cur_addr,
    output logic [WORD_W-1:0] o_console_lamps,
    output logic [RES_W-1:0] o_result,
    output logic o_busy,
    output logic o_done
);
    if (LINES != (1 << IDX_W)) begin : g_lines_check
        $error("LINES must equal 2**IDX_W");
    end

    typedef struct packed {
        state_e st;
        logic [ADDR_W-1:0] cur_addr;
        logic [ADDR_W-1:0] saved;
        logic blk;
        logic [WORD_W-1:0] lamps;
        logic [RES_W-1:0] result;
        logic busy;
        logic done;
        logic [LINES-1:0] lru;
        key_s [1:0][LINES-1:0] keys;
        logic [1:0][LINES*WORDS_PER_LINE-1:0][WORD_W-1:0] words;
    } state_s;

    state_s r;
    state_s next_r;
    logic wr_en;
    logic [IDX_W+1:0] wr_idx;
    logic [WORD_W-1:0] wr_data;

    function automatic logic [IDX_W+1:0] word_index(input logic [ADDR_W-1:0] a);
        word_index = a[ADDR_IDX_LSB+IDX_W-1:0];
    endfunction : word_index

    function automatic logic [IDX_W-1:0] line_index(input logic [ADDR_W-1:0] a);
        line_index = a[ADDR_IDX_LSB+IDX_W-1:ADDR_IDX_LSB];
    endfunction : line_index

    always_comb begin
        logic [ADDR_W-1:0] a;
        logic [IDX_W-1:0] li;
        key_s ka;
        key_s kb;
        logic hit;
        a = '0;
        li = '0;
        ka = '0;
        kb = '0;
        hit = 1'b0;
        next_r = r;
        next_r.done = 1'b0;
        wr_en = 1'b0;
        wr_idx = '0;
        wr_data = '0;
        unique case (r.st)
            ST_IDLE: begin
                if (i_addr_load_en) begin
                    next_r.cur_addr = i_addr_load;
                end
                if (i_start) begin
                    unique case (i_op)
                        OP_CON_WRITE: begin
                            a = r.cur_addr;
                            wr_en = 1'b1;
                            wr_idx = word_index(a);
                            wr_data = i_console_switches;
                            next_r.blk = i_block_sel;
                            next_r.done = 1'b1;
                        end
                        OP_CON_READ: begin
                            a = r.cur_addr;
                            next_r.lamps = r.words[i_block_sel][word_index(a)];
                            next_r.done = 1'b1;
                        end
                        OP_DIAG_WRITE: begin
                            next_r.saved = r.cur_addr;
                            next_r.blk = i_block_sel;
                            next_r.st = ST_LOAD;
                            next_r.busy = 1'b1;
                        end
                        OP_DIAG_READ: begin
                            a = i_field_ptr_reg;
                            next_r.result = {{(RES_W-WORD_W){1'b0}},
                                r.words[i_block_sel][word_index(a)]};
                            next_r.done = 1'b1;
                        end
                        OP_KEY_READ: begin
                            a = i_field_ptr_reg;
                            li = line_index(a);
                            ka = r.keys[0][li];
                            kb = r.keys[1][li];
                            hit = (ka.valid && ka.key == a[ADDR_W-1:ADDR_KEY_LSB]) ||
                                (kb.valid && kb.key == a[ADDR_W-1:ADDR_KEY_LSB]);
                            next_r.result = '0;
                            next_r.result[RES_KEYA_LSB +: KEY_W] = ka.key;
                            next_r.result[RES_VALA_BIT] = ka.valid;
                            next_r.result[RES_PARA_BIT] = ka.parity;
                            next_r.result[RES_KEYB_LSB +: KEY_W] = kb.key;
                            next_r.result[RES_VALB_BIT] = kb.valid;
                            next_r.result[RES_PARB_BIT] = kb.parity;
                            next_r.result[RES_HIT_BIT] = hit;
                            next_r.result[RES_LRU_BIT] = r.lru[li];
                            next_r.done = 1'b1;
                        end
                        default: begin
                            next_r.done = 1'b1;
                        end
                    endcase
                end
            end
            ST_LOAD: begin
                next_r.cur_addr = i_field_ptr_reg;
                next_r.st = ST_W0;
            end
            ST_W0, ST_W1, ST_W2, ST_W3: begin
                a = r.cur_addr;
                wr_en = 1'b1;
                wr_idx = {line_index(a), 2'(r.st - ST_W0)};
                unique case (r.st)
                    ST_W0: wr_data = i_src.x;
                    ST_W1: wr_data = i_src.y;
                    ST_W2: wr_data = i_src.t;
                    default: wr_data = i_src.l;
                endcase
                next_r.st = (r.st == ST_W3) ? ST_RESTORE : state_e'(r.st + 3'h1);
            end
            ST_RESTORE: begin
                next_r.cur_addr = r.saved;
                next_r.st = ST_IDLE;
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
            end
            default: begin
                next_r.st = ST_IDLE;
            end
        endcase
        if (wr_en) begin
            li = line_index(a);
            // Same key entry on every write of the line
            next_r.keys[next_r.blk][li].key = a[ADDR_W-1:ADDR_KEY_LSB];
            next_r.keys[next_r.blk][li].valid = 1'b1;
            next_r.keys[next_r.blk][li].parity =
                ~^{1'b1, a[ADDR_W-1:ADDR_KEY_LSB]};
            next_r.lru[li] = ~next_r.blk;
            next_r.words[next_r.blk][wr_idx] = wr_data;
        end
        if (i_srst || i_periodic_general_clear) begin
            next_r = '0;
            next_r.st = ST_IDLE;
            next_r.cur_addr = ADDR_RST;
            next_r.lamps = WORD_RST;
            // Data words survive a clear; the key store decides what is valid
            next_r.words = r.words;
            if (i_cache_only) begin
                next_r.keys = r.keys;
                next_r.lru = r.lru;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        r <= next_r;
    end

    assign o_cur_addr = r.cur_addr;
    assign o_console_lamps = r.lamps;
    assign o_result = r.result;
    assign o_busy = r.busy;
    assign o_done = r.done;

    AST_LOAD_FIELD: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (r.st == ST_LOAD && !i_periodic_general_clear) |=> r.cur_addr == $past(i_field_ptr_reg))
        else $error("field pointer not loaded");
    AST_RESTORE: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (r.st == ST_RESTORE && !i_periodic_general_clear) |=> r.cur_addr == $past(r.saved))
        else $error("address not restored");
    AST_SEQ_LEN: assert property (
        @(posedge i_clk) disable iff (i_srst || i_periodic_general_clear)
        (r.st == ST_IDLE && i_start && i_op == OP_DIAG_WRITE) |=> ##6 o_done)
        else $error("diagnostic write length wrong");
    AST_KEY_VALID: assert property (
        @(posedge i_clk) disable iff (i_srst || i_periodic_general_clear)
        (r.st == ST_W0) |=> r.keys[r.blk][line_index(r.cur_addr)].valid)
        else $error("key not validated");
    AST_KEY_PAR: assert property (
        @(posedge i_clk) disable iff (i_srst || i_periodic_general_clear)
        (r.st == ST_W1) |-> ^{r.keys[r.blk][line_index(r.cur_addr)]} == 1'b1)
        else $error("key parity not odd");
    AST_CLEAR: assert property (
        @(posedge i_clk)
        (i_periodic_general_clear && !i_cache_only) |=> (r.keys == '0 && !o_busy))
        else $error("general clear incomplete");
    AST_KEEP: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (i_periodic_general_clear && i_cache_only) |=> r.keys == $past(r.keys))
        else $error("cache-only clear lost keys");
    AST_BUSY: assert property (
        @(posedge i_clk) disable iff (i_srst || i_periodic_general_clear)
        $rose(o_busy) |-> o_busy [*5])
        else $error("busy too short");
    AST_ADDR_HELD: assert property (
        @(posedge i_clk) disable iff (i_srst || i_periodic_general_clear)
        (r.st inside {ST_W0, ST_W1, ST_W2, ST_W3}) |=> $stable(r.cur_addr))
        else $error("address moved during line write");
    AST_CON_KEY: assert property (
        @(posedge i_clk) disable iff (i_srst || i_periodic_general_clear)
        (r.st == ST_IDLE && i_start && i_op == OP_CON_WRITE) |=>
        r.keys[$past(i_block_sel)][$past(line_index(r.cur_addr))].key ==
        $past(r.cur_addr[ADDR_W-1:ADDR_KEY_LSB]))
        else $error("console write key wrong");
    AST_BUSY_STATE: assert property (
        @(posedge i_clk) disable iff (i_srst)
        o_busy == (r.st != ST_IDLE))
        else $error("busy flag out of step");
endmodule : cache_diagnostic_access

// ===== tb/seq_model.sv
// Model of the sequencer working registers that feed the cache unit
module seq_model
    import cache_diag_pkg::*;
(
    input wire logic [4*DATA_W-1:0] i_data,
    input wire logic [DATA_W-1:0] i_switch_data,
    output src_s o_src,
    output logic [WORD_W-1:0] o_switches
);
    timeunit 1ns;
    timeprecision 1ns;
    // Top bit makes the whole word odd parity
    function automatic logic [WORD_W-1:0] odd_word(input logic [DATA_W-1:0] d);
        return {~^d, d};
    endfunction : odd_word
    assign o_src.x = odd_word(i_data[63:48]);
    assign o_src.y = odd_word(i_data[47:32]);
    assign o_src.t = odd_word(i_data[31:16]);
    assign o_src.l = odd_word(i_data[15:0]);
    assign o_switches = odd_word(i_switch_data);
endmodule : seq_model

// ===== tb/cache_diagnostic_access_tb.sv
// Self-checking testbench for the cache diagnostic access unit
module cache_diagnostic_access_tb
    import cache_diag_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, srst = 1, gclr = 0, conly = 0, start = 0, aload_en = 0, blk = 0;
    op_e op = OP_CON_READ;
    logic [15:0] fptr = 16'h0000, aload = 16'h0000, swd = 16'h0000;
    logic [63:0] dat = 64'h0;
    src_s src;
    logic [16:0] sw;
    logic [15:0] cur, ca [0:20];
    logic [0:20] bz;
    logic [16:0] lamps;
    logic [23:0] res;
    logic busy, done;
    int err_total = 0, check_count = 0, n;
    seq_model partner (.i_data(dat), .i_switch_data(swd), .o_src(src), .o_switches(sw));
    cache_diagnostic_access dut (.i_clk(clk), .i_srst(srst), .i_periodic_general_clear(gclr),
        .i_cache_only(conly), .i_start(start), .i_op(op), .i_field_ptr_reg(fptr),
        .i_addr_load(aload), .i_addr_load_en(aload_en), .i_console_switches(sw),
        .i_src(src), .i_block_sel(blk), .o_cur_addr(cur), .o_console_lamps(lamps),
        .o_result(res), .o_busy(busy), .o_done(done));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            err_total++;
        end
    endtask : check
    // Starts one operation and records the address register each cycle until done
    task automatic run(input op_e o);
        @(posedge clk);
        #10 start = 1;
        op = o;
        for (n = 1; n <= 20; n++) begin
            @(posedge clk);
            #10 start = 0;
            ca[n] = cur;
            bz[n] = busy;
            if (done === 1'b1) break;
        end
        if (n > 20) begin
            err_total++;
            end_of_test();
        end
    endtask : run
    task automatic pulse_clear(input logic keep);
        @(posedge clk);
        #10 conly = keep;
        gclr = 1;
        @(posedge clk);
        #10 gclr = 0;
    endtask : pulse_clear
    function automatic logic [9:0] key_ent(input logic [7:0] k);
        return {~^{k, 1'b1}, 1'b1, k};
    endfunction : key_ent
    initial begin
        repeat (2) @(posedge clk);
        #10 srst = 0;
        check({8'h00, cur}, 24'h000000);
        check(res, 24'h000000);
        $display("Test reset done");
        @(posedge clk);
        #10 aload = 16'h3a15;
        aload_en = 1;
        swd = 16'hbeef;
        @(posedge clk);
        #10 aload_en = 0;
        run(OP_CON_WRITE);
        check(24'(n), 24'h000001);
        run(OP_CON_READ);
        check({7'h00, lamps}, {7'h00, ~^16'hbeef, 16'hbeef});
        $display("Test console done");
        fptr = 16'h5c24;
        dat = 64'h1234_8001_ffff_0f0e;
        blk = 1;
        run(OP_DIAG_WRITE);
        check(24'(n), 24'h000007);
        check({23'h000000, bz[1]}, 24'h000001);
        check({23'h000000, bz[7]}, 24'h000000);
        check({8'h00, ca[3]}, {8'h00, fptr});
        check({8'h00, ca[7]}, 24'h003a15);
        for (int w = 0; w < 4; w++) begin
            fptr[1:0] = w[1:0];
            run(OP_DIAG_READ);
            check({7'h00, res[16:0]},
                {7'h00, ~^dat[63-16*w -: 16], dat[63-16*w -: 16]});
        end
        run(OP_KEY_READ);
        check({14'h0000, res[19:10]}, {14'h0000, key_ent(8'h5c)});
        check({14'h0000, res[9:0]}, 24'h000000);
        check({22'h000000, res[21:20]}, 24'h000001);
        fptr = 16'h3a14;
        run(OP_KEY_READ);
        check({14'h0000, res[9:0]}, {14'h0000, key_ent(8'h3a)});
        check({22'h000000, res[21:20]}, 24'h000003);
        fptr = 16'h7714;
        run(OP_KEY_READ);
        check({23'h000000, res[20]}, 24'h000000);
        $display("Test diagnostic done");
        pulse_clear(1'b1);
        check({8'h00, cur}, 24'h000000);
        run(OP_KEY_READ);
        check({23'h000000, res[8]}, 24'h000001);
        pulse_clear(1'b0);
        run(OP_KEY_READ);
        check({23'h000000, res[8]}, 24'h000000);
        $display("Test clear done");
        @(posedge clk);
        #10 start = 1;
        op = OP_DIAG_WRITE;
        @(posedge clk);
        #10 start = 0;
        srst = 1;
        repeat (2) @(posedge clk);
        #10 srst = 0;
        check({22'h000000, busy, done}, 24'h000000);
        run(OP_CON_WRITE);
        check(24'(n), 24'h000001);
        fptr = 16'h0000;
        run(OP_KEY_READ);
        check({14'h0000, res[19:10]}, {14'h0000, key_ent(8'h00)});
        check({23'h000000, res[20]}, 24'h000001);
        $display("Test reset again done");
        end_of_test();
    end
endmodule : cache_diagnostic_access_tb
